/* File: logic/afflag_cfg.svh */
// Constants of the analog fault flag register
// Operation
// - Top bit reads the inverse of the present fault pin level, read only.
// - Bit 13 sets when the combined output leaves its supply rails.
// - Bit 11 sets on a positive converter short circuit.
// - Bit 9 sets when the positive converter cannot reach its target.
// - Bit 7 sets on current output open circuit or missing headroom.
// - Bit 6 sets on a voltage output short circuit.
// - Bit 5 sets on converter die overheat, bit 4 on main die overheat.
// - Bit 3 sets on reference output window fault or current limit.
// - Bit 2 sets on reference input window fault.
// - Bit 1 sets on internal analog supply window fault.
// - Bit 0 sets on regulator window fault or current limit.
// - Flags stay set until host writes one; writing zero changes nothing.
// - A flag whose diagnostic is disabled reads back as zero.
`ifndef AFFLAG_CFG_SVH
`define AFFLAG_CFG_SVH

`define AFF_REG_ADDR 5'h15
`define AFF_ADDR_W 5
`define AFF_DATA_W 22
`define AFF_FLAG_W 14
`define AFF_SRC_W 15
`define AFF_FLAG_MASK 14'h2AFF
`define AFF_FLAG_RESET 14'h0000
`define AFF_RDATA_RESET 22'h000000

`define AFF_BIT_PIN 21
`define AFF_ADDR_HI 20
`define AFF_ADDR_LO 16
`define AFF_RSV_HI 15
`define AFF_RSV_LO 14
`define AFF_BIT_OV 13
`define AFF_BIT_PSC 11
`define AFF_BIT_PREG 9
`define AFF_BIT_IOC 7
`define AFF_BIT_VSC 6
`define AFF_BIT_CHOT 5
`define AFF_BIT_MHOT 4
`define AFF_BIT_ROUT 3
`define AFF_BIT_RIN 2
`define AFF_BIT_AVCC 1
`define AFF_BIT_LDO 0

`define AFF_SRC_OV 0
`define AFF_SRC_PSC 1
`define AFF_SRC_PREG 2
`define AFF_SRC_IOPEN 3
`define AFF_SRC_IHEAD 4
`define AFF_SRC_VSC 5
`define AFF_SRC_CHOT 6
`define AFF_SRC_MHOT 7
`define AFF_SRC_RWIN 8
`define AFF_SRC_RLIM 9
`define AFF_SRC_RIN 10
`define AFF_SRC_AVCC 11
`define AFF_SRC_LWIN 12
`define AFF_SRC_LLIM 13
`define AFF_SRC_PIN 14
// Synchroniser reset, fault pin stage at its idle high level
`define AFF_SYNC_RESET 15'h4000

`endif

/* File: logic/afflag_pkg.sv */
// Types and helpers of the analog fault flag register
`include "afflag_cfg.svh"
package afflag_pkg;
    typedef logic [`AFF_ADDR_W-1:0] afflag_addr_t;
    typedef logic [`AFF_DATA_W-1:0] afflag_data_t;
    typedef logic [`AFF_FLAG_W-1:0] afflag_vec_t;
    typedef logic [`AFF_SRC_W-1:0] afflag_src_t;

    typedef struct packed {
        afflag_src_t s1;
        afflag_src_t s2;
    } afflag_sync_st_t;

    typedef struct packed {
        afflag_vec_t flags;
    } afflag_sticky_st_t;

    typedef struct packed {
        afflag_data_t rdata;
        logic rvalid;
    } afflag_top_st_t;

    function automatic logic afflag_hit(input afflag_addr_t addr);
        afflag_hit = (addr == `AFF_REG_ADDR);
    endfunction
endpackage

/* File: logic/afflag_sync.sv */
// Two-stage synchroniser for the analog fault inputs and fault pin
`timescale 1ns/1ps
`default_nettype none
`include "afflag_cfg.svh"
module afflag_sync (
    input wire logic core_clk,
    input wire logic rstn,
    input wire afflag_pkg::afflag_src_t async_in,
    output afflag_pkg::afflag_src_t sync_out
);
    import afflag_pkg::*;

    afflag_sync_st_t st;
    afflag_sync_st_t next_st;

    always_comb begin
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            // No false fault pin status just after reset
            st.s1 <= `AFF_SYNC_RESET;
            st.s2 <= `AFF_SYNC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.s2;
endmodule
`default_nettype wire

/* File: logic/afflag_sticky.sv */
// Sticky write-one-to-clear flag bank
`timescale 1ns/1ps
`default_nettype none
`include "afflag_cfg.svh"
module afflag_sticky (
    input wire logic core_clk,
    input wire logic rstn,
    input wire afflag_pkg::afflag_vec_t set_vec,
    input wire afflag_pkg::afflag_vec_t clr_vec,
    output afflag_pkg::afflag_vec_t flags
);
    import afflag_pkg::*;

    afflag_sticky_st_t st;
    afflag_sticky_st_t next_st;

    // Set wins over a clear in the same cycle
    always_comb begin
        next_st.flags = ((st.flags & ~clr_vec) | set_vec) & `AFF_FLAG_MASK;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st.flags <= `AFF_FLAG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
endmodule
`default_nettype wire

/* File: logic/afflag_top.sv */
// Analog fault flag register: sticky fault flags with host readback
`timescale 1ns/1ps
`default_nettype none
`include "afflag_cfg.svh"
module afflag_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire afflag_pkg::afflag_addr_t reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire afflag_pkg::afflag_data_t reg_wdata,
    output afflag_pkg::afflag_data_t reg_rdata,
    output logic reg_rvalid,
    input wire afflag_pkg::afflag_vec_t diag_en,
    input wire logic combined_output_pin_overrange,
    input wire logic pos_converter_short,
    input wire logic pos_converter_underreg,
    input wire logic current_output_open,
    input wire logic current_output_no_headroom,
    input wire logic voltage_output_short,
    input wire logic converter_die_hot,
    input wire logic main_die_hot,
    input wire logic reference_output_node_window,
    input wire logic reference_output_node_ilim,
    input wire logic reference_input_node_window,
    input wire logic internal_analog_supply_node_window,
    input wire logic regulator_output_node_window,
    input wire logic regulator_output_node_ilim,
    input wire logic fault_pin_n
);
    import afflag_pkg::*;

    // ****************************************
    // Input synchronisation
    // ****************************************
    afflag_src_t src_raw;
    afflag_src_t src;

    always_comb begin
        src_raw = '0;
        src_raw[`AFF_SRC_OV] = combined_output_pin_overrange;
        src_raw[`AFF_SRC_PSC] = pos_converter_short;
        src_raw[`AFF_SRC_PREG] = pos_converter_underreg;
        src_raw[`AFF_SRC_IOPEN] = current_output_open;
        src_raw[`AFF_SRC_IHEAD] = current_output_no_headroom;
        src_raw[`AFF_SRC_VSC] = voltage_output_short;
        src_raw[`AFF_SRC_CHOT] = converter_die_hot;
        src_raw[`AFF_SRC_MHOT] = main_die_hot;
        src_raw[`AFF_SRC_RWIN] = reference_output_node_window;
        src_raw[`AFF_SRC_RLIM] = reference_output_node_ilim;
        src_raw[`AFF_SRC_RIN] = reference_input_node_window;
        src_raw[`AFF_SRC_AVCC] = internal_analog_supply_node_window;
        src_raw[`AFF_SRC_LWIN] = regulator_output_node_window;
        src_raw[`AFF_SRC_LLIM] = regulator_output_node_ilim;
        src_raw[`AFF_SRC_PIN] = fault_pin_n;
    end

    afflag_sync u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in(src_raw),
        .sync_out(src)
    );

    // ****************************************
    // Flag set conditions
    // ****************************************
    afflag_vec_t cond;
    afflag_vec_t set_vec;
    afflag_vec_t clr_vec;
    afflag_vec_t flags;
    logic wr_hit;
    logic rd_hit;

    always_comb begin
        cond = '0;
        cond[`AFF_BIT_OV] = src[`AFF_SRC_OV];
        cond[`AFF_BIT_PSC] = src[`AFF_SRC_PSC];
        cond[`AFF_BIT_PREG] = src[`AFF_SRC_PREG];
        cond[`AFF_BIT_IOC] = src[`AFF_SRC_IOPEN] | src[`AFF_SRC_IHEAD];
        cond[`AFF_BIT_VSC] = src[`AFF_SRC_VSC];
        cond[`AFF_BIT_CHOT] = src[`AFF_SRC_CHOT];
        cond[`AFF_BIT_MHOT] = src[`AFF_SRC_MHOT];
        cond[`AFF_BIT_ROUT] = src[`AFF_SRC_RWIN] | src[`AFF_SRC_RLIM];
        cond[`AFF_BIT_RIN] = src[`AFF_SRC_RIN];
        cond[`AFF_BIT_AVCC] = src[`AFF_SRC_AVCC];
        cond[`AFF_BIT_LDO] = src[`AFF_SRC_LWIN] | src[`AFF_SRC_LLIM];
    end

    // Disabled diagnostics neither set nor show their flag
    assign set_vec = cond & diag_en & `AFF_FLAG_MASK;
    assign wr_hit = reg_wr & afflag_hit(reg_addr);
    assign rd_hit = reg_rd & afflag_hit(reg_addr);
    // Write one clears, write zero leaves the flag alone
    assign clr_vec = wr_hit ? reg_wdata[`AFF_FLAG_W-1:0] : '0;

    afflag_sticky u_sticky (
        .core_clk(core_clk),
        .rstn(rstn),
        .set_vec(set_vec),
        .clr_vec(clr_vec),
        .flags(flags)
    );

    // ****************************************
    // Readback
    // ****************************************
    afflag_top_st_t st;
    afflag_top_st_t next_st;

    always_comb begin
        next_st.rvalid = reg_rd;
        next_st.rdata = '0;
        if (rd_hit) begin
            next_st.rdata[`AFF_BIT_PIN] = ~src[`AFF_SRC_PIN];
            next_st.rdata[`AFF_ADDR_HI:`AFF_ADDR_LO] = `AFF_REG_ADDR;
            next_st.rdata[`AFF_FLAG_W-1:0] = flags & diag_en;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st.rdata <= `AFF_RDATA_RESET;
            st.rvalid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_read;
        reg_rd && afflag_hit(reg_addr);
    endsequence

    sequence s_answer;
        ##1 reg_rvalid;
    endsequence

    chk_pin_inverse: assert property (
        s_read |=> reg_rdata[`AFF_BIT_PIN] == !$past(src[`AFF_SRC_PIN]))
        else $error("fault pin status not inverse of pin");

    chk_pin_path: assert property (
        $stable(fault_pin_n) [*3] ##0 s_read
        |=> reg_rdata[`AFF_BIT_PIN] == !$past(fault_pin_n))
        else $error("fault pin status lags a steady pin");

    chk_overvoltage_set: assert property (
        combined_output_pin_overrange && diag_en[`AFF_BIT_OV]
        ##1 diag_en[`AFF_BIT_OV] ##1 diag_en[`AFF_BIT_OV]
        |=> flags[`AFF_BIT_OV])
        else $error("overvoltage flag not set");

    chk_conv_short_set: assert property (
        set_vec[`AFF_BIT_PSC] |=> flags[`AFF_BIT_PSC])
        else $error("converter short flag not set");

    chk_conv_reg_set: assert property (
        src[`AFF_SRC_PREG] && diag_en[`AFF_BIT_PREG] |=> flags[`AFF_BIT_PREG])
        else $error("converter regulation flag not set");

    chk_open_set: assert property (
        (src[`AFF_SRC_IOPEN] || src[`AFF_SRC_IHEAD]) && diag_en[`AFF_BIT_IOC]
        |=> flags[`AFF_BIT_IOC])
        else $error("current open flag not set");

    chk_vshort_set: assert property (
        src[`AFF_SRC_VSC] && diag_en[`AFF_BIT_VSC] |=> flags[`AFF_BIT_VSC])
        else $error("voltage short flag not set");

    chk_die_hot_set: assert property (
        src[`AFF_SRC_CHOT] && diag_en[`AFF_BIT_CHOT] && !src[`AFF_SRC_MHOT]
        && !flags[`AFF_BIT_MHOT]
        |=> flags[`AFF_BIT_CHOT] && !flags[`AFF_BIT_MHOT])
        else $error("die temperature flags not independent");

    chk_reference_output_node_set: assert property (
        (src[`AFF_SRC_RWIN] || src[`AFF_SRC_RLIM]) && diag_en[`AFF_BIT_ROUT]
        |=> flags[`AFF_BIT_ROUT])
        else $error("reference output flag not set");

    chk_reference_input_node_set: assert property (
        src[`AFF_SRC_RIN] && diag_en[`AFF_BIT_RIN] |=> flags[`AFF_BIT_RIN])
        else $error("reference input flag not set");

    chk_supply_set: assert property (
        src[`AFF_SRC_AVCC] && diag_en[`AFF_BIT_AVCC] |=> flags[`AFF_BIT_AVCC])
        else $error("internal supply flag not set");

    chk_regulator_set: assert property (
        (src[`AFF_SRC_LWIN] || src[`AFF_SRC_LLIM]) && diag_en[`AFF_BIT_LDO]
        |=> flags[`AFF_BIT_LDO])
        else $error("regulator flag not set");

    chk_flag_hold: assert property (
        1'b1 |=> (flags & $past(flags & ~clr_vec)) == $past(flags & ~clr_vec))
        else $error("flag dropped without a write of one");

    chk_flag_clear: assert property (
        wr_hit && !set_vec[`AFF_BIT_OV] && reg_wdata[`AFF_BIT_OV]
        |=> !flags[`AFF_BIT_OV])
        else $error("write of one did not clear flag");

    chk_disabled_zero: assert property (
        s_read |=> (reg_rdata[`AFF_FLAG_W-1:0] & ~$past(diag_en)) == '0)
        else $error("disabled diagnostic flag read as one");

    chk_addr_field: assert property (
        s_read |=> reg_rdata[`AFF_ADDR_HI:`AFF_ADDR_LO] == `AFF_REG_ADDR
        && reg_rdata[`AFF_RSV_HI:`AFF_RSV_LO] == 2'h0)
        else $error("address or reserved field wrong on readback");

    chk_read_answer: assert property (
        s_read |-> s_answer)
        else $error("read not answered in one cycle");

    chk_set_wins: assert property (
        wr_hit && (reg_wdata[`AFF_FLAG_W-1:0] & set_vec) != '0
        |=> (flags & $past(set_vec)) == $past(set_vec))
        else $error("present condition lost on clear");

    sequence s_raw_seen(raw, en);
        raw && en ##1 en ##1 en;
    endsequence

    chk_short_path: assert property (
        s_raw_seen(pos_converter_short, diag_en[`AFF_BIT_PSC])
        |=> flags[`AFF_BIT_PSC])
        else $error("converter short input did not reach its flag");

    chk_underreg_path: assert property (
        s_raw_seen(pos_converter_underreg, diag_en[`AFF_BIT_PREG])
        |=> flags[`AFF_BIT_PREG])
        else $error("converter regulation input did not reach its flag");

    chk_headroom_path: assert property (
        s_raw_seen(current_output_no_headroom, diag_en[`AFF_BIT_IOC])
        |=> flags[`AFF_BIT_IOC])
        else $error("headroom input did not reach its flag");

    chk_vshort_path: assert property (
        s_raw_seen(voltage_output_short, diag_en[`AFF_BIT_VSC])
        |=> flags[`AFF_BIT_VSC])
        else $error("voltage short input did not reach its flag");

    chk_main_hot_path: assert property (
        s_raw_seen(main_die_hot, diag_en[`AFF_BIT_MHOT])
        |=> flags[`AFF_BIT_MHOT])
        else $error("main die temperature input did not reach its flag");

    chk_reference_output_node_limit: assert property (
        s_raw_seen(reference_output_node_ilim, diag_en[`AFF_BIT_ROUT])
        |=> flags[`AFF_BIT_ROUT])
        else $error("reference output limit did not reach its flag");

    chk_reference_input_node_path: assert property (
        s_raw_seen(reference_input_node_window, diag_en[`AFF_BIT_RIN])
        |=> flags[`AFF_BIT_RIN])
        else $error("reference input fault did not reach its flag");

    chk_supply_path: assert property (
        s_raw_seen(internal_analog_supply_node_window, diag_en[`AFF_BIT_AVCC])
        |=> flags[`AFF_BIT_AVCC])
        else $error("internal supply fault did not reach its flag");

    chk_regulator_path: assert property (
        s_raw_seen(regulator_output_node_ilim, diag_en[`AFF_BIT_LDO])
        |=> flags[`AFF_BIT_LDO])
        else $error("regulator limit did not reach its flag");

    chk_clear_all: assert property (
        wr_hit
        |=> (flags & $past(reg_wdata[`AFF_FLAG_W-1:0] & ~set_vec)) == '0)
        else $error("write of one left a flag set");

    chk_no_stray_set: assert property (
        1'b1
        |=> (flags & ~$past(flags | set_vec)) == '0)
        else $error("flag set without a present condition");

    chk_disabled_no_set: assert property (
        !diag_en[`AFF_BIT_CHOT] && !flags[`AFF_BIT_CHOT]
        |=> !flags[`AFF_BIT_CHOT])
        else $error("disabled diagnostic set its flag");

    chk_miss_read: assert property (
        reg_rd && !afflag_hit(reg_addr)
        |=> reg_rvalid && reg_rdata == '0)
        else $error("read of another address not answered with zero");

    chk_idle_quiet: assert property (
        !reg_rd
        |=> !reg_rvalid && reg_rdata == '0)
        else $error("read port active without a read");

    chk_reserved_zero: assert property (
        s_read
        |=> (reg_rdata[`AFF_FLAG_W-1:0] & ~`AFF_FLAG_MASK) == '0)
        else $error("reserved flag position read as one");
endmodule
`default_nettype wire

/* File: dv/afflag_top_tb.sv */
// Self-checking testbench of the analog fault flag register
`timescale 1ns/1ps
`default_nettype none
module afflag_top_tb;
    import afflag_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic core_clk;
    logic rstn;
    afflag_addr_t reg_addr;
    logic reg_rd;
    logic reg_wr;
    afflag_data_t reg_wdata;
    afflag_data_t reg_rdata;
    logic reg_rvalid;
    afflag_vec_t diag_en;
    logic [13:0] flt;
    logic fault_pin_n;
    int n_fail;
    int n_tests;
    // Flag bit fed by each fault input
    localparam int TGT[14] = '{13, 11, 9, 7, 7, 6, 5, 4, 3, 3, 2, 1, 0, 0};

    afflag_top dut (
        .core_clk(core_clk),
        .rstn(rstn),
        .reg_addr(reg_addr),
        .reg_rd(reg_rd),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .diag_en(diag_en),
        .combined_output_pin_overrange(flt[0]),
        .pos_converter_short(flt[1]),
        .pos_converter_underreg(flt[2]),
        .current_output_open(flt[3]),
        .current_output_no_headroom(flt[4]),
        .voltage_output_short(flt[5]),
        .converter_die_hot(flt[6]),
        .main_die_hot(flt[7]),
        .reference_output_node_window(flt[8]),
        .reference_output_node_ilim(flt[9]),
        .reference_input_node_window(flt[10]),
        .internal_analog_supply_node_window(flt[11]),
        .regulator_output_node_window(flt[12]),
        .regulator_output_node_ilim(flt[13]),
        .fault_pin_n(fault_pin_n)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input afflag_data_t got, input afflag_data_t exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic afflag_data_t word(input afflag_vec_t f);
        return {~fault_pin_n, 5'h15, 2'b00, f};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic rd(input afflag_addr_t a, input afflag_data_t exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check({21'h000000, reg_rvalid}, 22'h000001);
        check(reg_rdata, exp);
        @(posedge core_clk);
        #1;
        check({21'h000000, reg_rvalid}, 22'h000000);
        check(reg_rdata, 22'h000000);
        @(posedge core_clk);
    endtask

    task automatic wr(input afflag_data_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= 5'h15;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Raise one fault input long enough to pass the synchroniser
    task automatic pulse(input int i);
        flt[i] <= 1'b1;
        cyc(4);
        flt[i] <= 1'b0;
        cyc(3);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #60000;
        n_fail++;
        finish_test();
    end

    initial begin
        rstn = 1'b0;
        reg_addr = 5'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 22'h000000;
        diag_en = 14'h3FFF;
        flt = 14'h0000;
        fault_pin_n = 1'b1;
        n_fail = 0;
        n_tests = 0;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        cyc(3);
        rd(5'h15, word(14'h0000));
        rd(5'h03, 22'h000000);
        fault_pin_n <= 1'b0;
        cyc(3);
        rd(5'h15, word(14'h0000));
        fault_pin_n <= 1'b1;
        cyc(3);
        // Each input sets its own flag, which stays until cleared by a one
        for (int i = 0; i < 14; i++) begin
            pulse(i);
            wr(22'h3FC000);
            rd(5'h15, word(14'h0001 << TGT[i]));
            wr(22'h000001 << TGT[i]);
            rd(5'h15, word(14'h0000));
        end
        // Disabled diagnostic neither sets nor shows its flag
        diag_en[5] <= 1'b0;
        pulse(6);
        diag_en[5] <= 1'b1;
        rd(5'h15, word(14'h0000));
        pulse(6);
        diag_en[5] <= 1'b0;
        rd(5'h15, word(14'h0000));
        diag_en[5] <= 1'b1;
        rd(5'h15, word(14'h0020));
        wr(22'h000020);
        rd(5'h15, word(14'h0000));
        // Clear while the condition persists leaves the flag set
        flt[7] <= 1'b1;
        cyc(4);
        wr(22'h000010);
        rd(5'h15, word(14'h0010));
        flt[7] <= 1'b0;
        cyc(3);
        wr(22'h000010);
        rd(5'h15, word(14'h0000));
        finish_test();
    end
endmodule
`default_nettype wire
